// File: rtl/pos_capture_pkg.sv
// Constants and types for the dual position edge capture block
package pos_capture_pkg;

  localparam int UNITS = 2;
  localparam int SYNC_STAGES = 2;

  // Parameter addresses
  localparam logic [15:0] CAPTURE_DONE_STATUS_ADDR = 16'h0a02;
  localparam logic [15:0] UNIT_ONE_EDGE_SELECT_ADDR = 16'h0a04;
  localparam logic [15:0] UNIT_TWO_EDGE_SELECT_ADDR = 16'h0a06;
  localparam logic [15:0] UNIT_ONE_ARM_CONTROL_ADDR = 16'h0a08;
  localparam logic [15:0] UNIT_TWO_ARM_CONTROL_ADDR = 16'h0a0a;
  localparam logic [15:0] UNIT_ONE_LATCHED_POSITION_ADDR = 16'h0a0c;
  localparam logic [15:0] UNIT_TWO_LATCHED_POSITION_ADDR = 16'h0a0e;
  localparam logic [15:0] UNIT_ONE_EVENT_TALLY_ADDR = 16'h0a10;
  localparam logic [15:0] UNIT_TWO_EVENT_TALLY_ADDR = 16'h0a12;

  // Status bit positions
  localparam int DONE_BIT_ONE = 0;
  localparam int DONE_BIT_TWO = 1;

  // Arm control codes
  localparam logic [15:0] ARM_STOP = 16'h0000;
  localparam logic [15:0] ARM_ONCE = 16'h0001;
  localparam logic [15:0] ARM_CONT = 16'h0002;

  // Edge select codes
  localparam logic EDGE_FALLING = 1'b0;
  localparam logic EDGE_RISING = 1'b1;

  // Reset values
  localparam logic EDGE_SELECT_RESET = 1'b0;
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_ONCE,
    MODE_CONT
  } arm_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } par_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } par_rsp_type;

endpackage

// File: rtl/dual_position_edge_capture.sv
// Two independent capture units latching motor position on input edges
`timescale 1ns/1ps
module dual_position_edge_capture (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Capture input lines
  input wire logic i_capture_input_one,
  input wire logic i_capture_input_two,
  // Position from motion core
  input wire logic signed [31:0] i_motor_pos,
  input wire logic i_ref_shift_valid,
  input wire logic signed [31:0] i_ref_shift,
  // Parameter access
  input wire pos_capture_pkg::par_req_type i_par_req,
  output pos_capture_pkg::par_rsp_type o_par_rsp
);
  import pos_capture_pkg::*;

  logic [UNITS-1:0] cap_in;
  logic [UNITS-1:0] sync1_q;
  logic [UNITS-1:0] sync2_q;
  logic [UNITS-1:0] prev_q;
  logic [UNITS-1:0] edge_sel_q;
  logic [UNITS-1:0] done_q;
  logic [UNITS-1:0] ev;
  logic [UNITS-1:0] arm_wr;
  logic [UNITS-1:0] sel_wr;
  arm_mode_type mode_q [UNITS];
  arm_mode_type arm_val;
  logic [15:0] tally_q [UNITS];
  logic signed [31:0] pos_q [UNITS];
  logic [31:0] rdata_d;
  logic arm_ok;

  function automatic logic edge_hit(input logic sel, input logic now,
                                    input logic prev);
    edge_hit = (sel == EDGE_RISING) ? (now & ~prev) : (~now & prev);
  endfunction

  function automatic logic [15:0] arm_addr(input int u);
    arm_addr = (u == 0) ? UNIT_ONE_ARM_CONTROL_ADDR
                        : UNIT_TWO_ARM_CONTROL_ADDR;
  endfunction

  function automatic logic [15:0] sel_addr(input int u);
    sel_addr = (u == 0) ? UNIT_ONE_EDGE_SELECT_ADDR
                        : UNIT_TWO_EDGE_SELECT_ADDR;
  endfunction

  function automatic logic [15:0] mode_code(input arm_mode_type m);
    case (m)
      MODE_ONCE: mode_code = ARM_ONCE;
      MODE_CONT: mode_code = ARM_CONT;
      default: mode_code = ARM_STOP;
    endcase
  endfunction

  assign cap_in = {i_capture_input_two, i_capture_input_one};

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (i_clk_en) begin
      sync1_q <= cap_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Arm value decode, out-of-range codes rejected
  always_comb begin
    arm_ok = 1'b1;
    case (i_par_req.wdata)
      ARM_STOP: arm_val = MODE_IDLE;
      ARM_ONCE: arm_val = MODE_ONCE;
      ARM_CONT: arm_val = MODE_CONT;
      default: begin
        arm_val = MODE_IDLE;
        arm_ok = 1'b0;
      end
    endcase
  end

  // Capture events and write strobes per unit
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      ev[u] = i_clk_en && (mode_q[u] != MODE_IDLE) &&
              edge_hit(edge_sel_q[u], sync2_q[u], prev_q[u]);
      arm_wr[u] = i_clk_en && i_par_req.wr && arm_ok &&
                  (i_par_req.addr == arm_addr(u));
      sel_wr[u] = i_clk_en && i_par_req.wr &&
                  (i_par_req.addr == sel_addr(u));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      edge_sel_q <= {UNITS{EDGE_SELECT_RESET}};
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        if (sel_wr[u]) begin
          edge_sel_q[u] <= i_par_req.wdata[0];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int u = 0; u < UNITS; u++) begin
        mode_q[u] <= MODE_IDLE;
      end
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        if (arm_wr[u]) begin
          mode_q[u] <= arm_val;
        end else if (ev[u] && mode_q[u] == MODE_ONCE) begin
          mode_q[u] <= MODE_IDLE;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int u = 0; u < UNITS; u++) begin
        tally_q[u] <= TALLY_RESET;
      end
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        if (arm_wr[u] && arm_val != MODE_IDLE) begin
          // Clear on activation, counting a same-cycle event
          tally_q[u] <= ev[u] ? 16'h0001 : TALLY_RESET;
        end else if (ev[u]) begin
          tally_q[u] <= tally_q[u] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int u = 0; u < UNITS; u++) begin
        pos_q[u] <= POSITION_RESET;
      end
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        if (ev[u]) begin
          pos_q[u] <= i_motor_pos;
        end else if (i_clk_en && i_ref_shift_valid) begin
          pos_q[u] <= pos_q[u] + i_ref_shift;
        end
      end
    end
  end

  // Done flags, set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      done_q <= '0;
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        if (ev[u]) begin
          done_q[u] <= 1'b1;
        end else if (arm_wr[u] && arm_val != MODE_IDLE) begin
          done_q[u] <= 1'b0;
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_d = READ_ZERO;
    case (i_par_req.addr)
      CAPTURE_DONE_STATUS_ADDR: rdata_d = {30'h0000_0000, done_q};
      UNIT_ONE_EDGE_SELECT_ADDR: rdata_d = {31'h0000_0000, edge_sel_q[0]};
      UNIT_TWO_EDGE_SELECT_ADDR: rdata_d = {31'h0000_0000, edge_sel_q[1]};
      UNIT_ONE_ARM_CONTROL_ADDR: rdata_d = {16'h0000, mode_code(mode_q[0])};
      UNIT_TWO_ARM_CONTROL_ADDR: rdata_d = {16'h0000, mode_code(mode_q[1])};
      UNIT_ONE_LATCHED_POSITION_ADDR: rdata_d = pos_q[0];
      UNIT_TWO_LATCHED_POSITION_ADDR: rdata_d = pos_q[1];
      UNIT_ONE_EVENT_TALLY_ADDR: rdata_d = {16'h0000, tally_q[0]};
      UNIT_TWO_EVENT_TALLY_ADDR: rdata_d = {16'h0000, tally_q[1]};
      default: rdata_d = READ_ZERO;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_par_rsp <= '0;
    end else if (i_clk_en) begin
      o_par_rsp.ack <= i_par_req.rd | i_par_req.wr;
      o_par_rsp.rdata <= i_par_req.rd ? rdata_d : READ_ZERO;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  once_disarm_a: assert property (
    ev[0] && mode_q[0] == MODE_ONCE && !arm_wr[0] |=> mode_q[0] == MODE_IDLE)
    else $error("single capture did not disarm");

  cont_stay_a: assert property (
    ev[1] && mode_q[1] == MODE_CONT && !arm_wr[1] |=> mode_q[1] == MODE_CONT)
    else $error("continuous capture dropped out");

  pos_latch_a: assert property (
    ev[0] |=> pos_q[0] == $past(i_motor_pos))
    else $error("captured position wrong");

  tally_inc_a: assert property (
    ev[0] && !arm_wr[0] |=> tally_q[0] == $past(tally_q[0]) + 16'h0001)
    else $error("tally did not count event");

  tally_clear_a: assert property (
    arm_wr[1] && arm_val != MODE_IDLE && !ev[1] |=> tally_q[1] == 16'h0000)
    else $error("tally not cleared on arm");

  done_set_a: assert property (
    ev[1] |=> done_q[1] ##1 (done_q[1] || $past(arm_wr[1])))
    else $error("done bit not set by capture");

  done_clear_a: assert property (
    arm_wr[0] && arm_val != MODE_IDLE && !ev[0] |=> !done_q[0])
    else $error("done bit not cleared on arm");

  cancel_stop_a: assert property (
    arm_wr[0] && arm_val == MODE_IDLE |=> mode_q[0] == MODE_IDLE && !ev[0])
    else $error("cancel did not stop unit");

  one_event_a: assert property (
    ev[0] |=> !ev[0])
    else $error("one edge gave two events");

  rebase_pos_a: assert property (
    i_clk_en && i_ref_shift_valid && !ev[1]
    |=> pos_q[1] == $past(pos_q[1]) + $past(i_ref_shift))
    else $error("held position not rebased");

  rebase_one_a: assert property (
    i_clk_en && i_ref_shift_valid && !ev[0]
    |=> pos_q[0] == $past(pos_q[0]) + $past(i_ref_shift))
    else $error("held position one not rebased");

  latch_two_a: assert property (
    ev[1] |=> pos_q[1] == $past(i_motor_pos))
    else $error("captured position two wrong");

  tally_two_a: assert property (
    ev[1] && !arm_wr[1] |=> tally_q[1] == $past(tally_q[1]) + 16'h0001)
    else $error("tally two did not count event");

  done_one_a: assert property (
    ev[0] |=> done_q[0])
    else $error("done bit one not set by capture");

  sel_store_a: assert property (
    sel_wr[0] |=> edge_sel_q[0] == $past(i_par_req.wdata[0]))
    else $error("edge select not stored");

  bad_code_a: assert property (
    i_clk_en && i_par_req.wr && i_par_req.wdata > ARM_CONT && !ev[1] &&
    i_par_req.addr == UNIT_TWO_ARM_CONTROL_ADDR
    |=> mode_q[1] == $past(mode_q[1]) && tally_q[1] == $past(tally_q[1]))
    else $error("out-of-range arm code acted");

  status_read_a: assert property (
    i_clk_en && i_par_req.rd && i_par_req.addr == CAPTURE_DONE_STATUS_ADDR
    |=> o_par_rsp.ack && o_par_rsp.rdata == {30'h0000_0000, $past(done_q)})
    else $error("status word read wrong");

endmodule

// File: sim/capture_source.sv
// Model of the two capture signal sources
`timescale 1ns/1ps
module capture_source (
  // Clock
  input wire logic i_sys_clk,
  // Capture lines
  output logic o_line_one,
  output logic o_line_two
);
  initial begin
    o_line_one = 1'b0;
    o_line_two = 1'b1;
  end
  task automatic drive(input int unit, input logic lvl);
    @(posedge i_sys_clk);
    #1;
    if (unit == 1) o_line_one = lvl;
    else o_line_two = lvl;
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask
endmodule

// File: sim/dual_position_edge_capture_tb_top.sv
// Self-checking bench for the dual position edge capture block
`timescale 1ns/1ps
module dual_position_edge_capture_tb_top;
  import pos_capture_pkg::*;
  logic i_sys_clk, i_reset, i_clk_en, i_ref_shift_valid;
  logic signed [31:0] i_motor_pos, i_ref_shift;
  logic cap_one, cap_two;
  par_req_type i_par_req;
  par_rsp_type o_par_rsp;
  logic [31:0] exp_q[$];
  logic [31:0] p1, p2;
  int n_errors = 0;
  int check_count = 0;

  dual_position_edge_capture u_dual_position_edge_capture (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_capture_input_one(cap_one), .i_capture_input_two(cap_two),
    .i_motor_pos(i_motor_pos), .i_ref_shift_valid(i_ref_shift_valid),
    .i_ref_shift(i_ref_shift), .i_par_req(i_par_req),
    .o_par_rsp(o_par_rsp));
  capture_source u_capture_source (.i_sys_clk(i_sys_clk),
    .o_line_one(cap_one), .o_line_two(cap_two));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One access, answer noted for the monitor
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d, input logic [31:0] e);
    @(posedge i_sys_clk);
    #1;
    i_par_req = '{wr: w, rd: !w, addr: a, wdata: d};
    exp_q.push_back(w ? READ_ZERO : e);
    @(posedge i_sys_clk);
    #1;
    i_par_req = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 16'h0000, e);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d, READ_ZERO);
  endtask

  // Oldest note against each answer
  always @(negedge i_sys_clk) begin
    if (o_par_rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) check("stray ack", 32'h0000_0001, READ_ZERO);
      else check("rdata", o_par_rsp.rdata, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  initial begin
    i_reset = 1'b1;
    i_clk_en = 1'b1;
    i_ref_shift_valid = 1'b0;
    i_motor_pos = '0;
    i_ref_shift = '0;
    i_par_req = '0;
    void'($urandom(28520));
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    for (int a = 16'h0a00; a <= 16'h0a12; a += 2)
      rd(16'(a), READ_ZERO);
    p1 = $urandom();
    i_motor_pos = p1;
    wr(UNIT_ONE_EDGE_SELECT_ADDR, 16'h0001);
    rd(UNIT_ONE_EDGE_SELECT_ADDR, 32'h0000_0001);
    wr(UNIT_ONE_ARM_CONTROL_ADDR, ARM_ONCE);
    u_capture_source.drive(1, 1'b1);
    i_motor_pos = $urandom();
    u_capture_source.drive(1, 1'b0);
    u_capture_source.drive(1, 1'b1);
    rd(UNIT_ONE_LATCHED_POSITION_ADDR, p1);
    rd(UNIT_ONE_EVENT_TALLY_ADDR, 32'h0000_0001);
    rd(UNIT_ONE_ARM_CONTROL_ADDR, READ_ZERO);
    rd(CAPTURE_DONE_STATUS_ADDR, 32'h0000_0001);
    wr(UNIT_TWO_ARM_CONTROL_ADDR, ARM_CONT);
    i_motor_pos = $urandom();
    u_capture_source.drive(2, 1'b0);
    i_motor_pos = $urandom();
    u_capture_source.drive(2, 1'b1);
    p2 = $urandom();
    i_motor_pos = p2;
    u_capture_source.drive(2, 1'b0);
    rd(UNIT_TWO_LATCHED_POSITION_ADDR, p2);
    rd(UNIT_TWO_EVENT_TALLY_ADDR, 32'h0000_0002);
    wr(UNIT_TWO_ARM_CONTROL_ADDR, 16'h0003);
    rd(UNIT_TWO_ARM_CONTROL_ADDR, 32'h0000_0002);
    rd(CAPTURE_DONE_STATUS_ADDR, 32'h0000_0003);
    wr(UNIT_TWO_ARM_CONTROL_ADDR, ARM_STOP);
    rd(UNIT_TWO_ARM_CONTROL_ADDR, READ_ZERO);
    i_motor_pos = $urandom();
    u_capture_source.drive(2, 1'b1);
    u_capture_source.drive(2, 1'b0);
    rd(UNIT_TWO_EVENT_TALLY_ADDR, 32'h0000_0002);
    rd(UNIT_TWO_LATCHED_POSITION_ADDR, p2);
    i_ref_shift = $urandom();
    @(posedge i_sys_clk);
    #1;
    i_ref_shift_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_ref_shift_valid = 1'b0;
    rd(UNIT_ONE_LATCHED_POSITION_ADDR, p1 + i_ref_shift);
    rd(UNIT_TWO_LATCHED_POSITION_ADDR, p2 + i_ref_shift);
    // Rebase pulse while frozen must not act
    @(posedge i_sys_clk);
    #1;
    i_clk_en = 1'b0;
    i_ref_shift_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_clk_en = 1'b1;
    i_ref_shift_valid = 1'b0;
    rd(UNIT_ONE_LATCHED_POSITION_ADDR, p1 + i_ref_shift);
    wr(UNIT_ONE_ARM_CONTROL_ADDR, ARM_ONCE);
    rd(UNIT_ONE_EVENT_TALLY_ADDR, READ_ZERO);
    rd(CAPTURE_DONE_STATUS_ADDR, 32'h0000_0002);
    rd(UNIT_ONE_ARM_CONTROL_ADDR, 32'h0000_0001);
    // Cancel a single capture still waiting
    wr(UNIT_ONE_ARM_CONTROL_ADDR, ARM_STOP);
    u_capture_source.drive(1, 1'b0);
    u_capture_source.drive(1, 1'b1);
    rd(UNIT_ONE_ARM_CONTROL_ADDR, READ_ZERO);
    rd(UNIT_ONE_EVENT_TALLY_ADDR, READ_ZERO);
    // Second reset in mid-run
    i_reset = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    rd(UNIT_TWO_LATCHED_POSITION_ADDR, POSITION_RESET);
    rd(UNIT_ONE_EDGE_SELECT_ADDR, READ_ZERO);
    rd(CAPTURE_DONE_STATUS_ADDR, READ_ZERO);
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge i_sys_clk);
    check("pending answers", 32'(exp_q.size()), READ_ZERO);
    complete_run();
  end
endmodule
